// ---- hw/ivm_cfg.svh ----
// Purpose: Constants for the interrupt vector and mask block
// Assumes: 8-bit register port, 3-bit register index
// Notes: Offsets are register indices on the plain register port
//
// Summary of operation
// - Vector is base byte, two zero bits, then six-bit source address.
// - Fixed source addresses; receiver highest, timer lowest, non-maskable unranked.
// - Mask bit high blocks its source at cpu_irq and vector, not in status or evt_irq; all-zero field blocks nothing.
// - Bidirectional pin as output is driven from mask bit 3.
`ifndef IVM_CFG_SVH
`define IVM_CFG_SVH

// Register indices
`define IVM_OFS_BASE 3'h0
`define IVM_OFS_CTRL 3'h1
`define IVM_OFS_CFG 3'h2
`define IVM_OFS_STAT 3'h3
`define IVM_OFS_EMSK 3'h4

// Reset values
`define IVM_RST_BASE 8'h00
`define IVM_RST_MASK 5'h00
`define IVM_RST_RIS 2'h0
`define IVM_RST_EMSK 6'h00

// Field positions in the control and config registers
`define IVM_CTRL_MASK_MSB 4
`define IVM_CTRL_RSV 5
`define IVM_CTRL_RIS_LSB 6
`define IVM_MASK_BIDIR 3
`define IVM_CFG_BIDIR_OUT 0

// Six-bit vector addresses per source
`define IVM_VA_NMI 6'h1C
`define IVM_VA_RX 6'h04
`define IVM_VA_TX 6'h08
`define IVM_VA_LTA 6'h0C
`define IVM_VA_BIDIR 6'h10
`define IVM_VA_TMR 6'h14

`endif

// ---- hw/ivm_pkg.sv ----
// Purpose: Types for the interrupt vector and mask block
// Assumes: Constants come from ivm_cfg.svh
// Notes: Source index 0 rx, 1 tx, 2 lta, 3 bidir, 4 timer, 5 nmi
package ivm_pkg;

	// Register port request
	typedef struct packed
	{
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ivm_bus_req_t;

	// Interrupt request lines from the processor's sources
	typedef struct packed
	{
		logic nmi;
		logic timer;
		logic lta;
		logic tx;
		logic rx;
	} ivm_src_t;

	// Whole state of the top module
	typedef struct packed
	{
		logic [7:0] base;
		logic [4:0] mask;
		logic [1:0] ris;
		logic bidir_out;
		logic [5:0] stat;
		logic [5:0] emask;
		logic [5:0] req_prev;
		logic [7:0] rdata;
		logic [15:0] vector;
		logic cpu_irq;
		logic evt_irq;
		logic pin_o;
		logic pin_oe;
	} ivm_state_t;

endpackage

// ---- hw/ivm_prio.sv ----
// Purpose: Fixed-priority pick among maskable sources
// Assumes: Index 0 is the highest priority
// Notes: Purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
`include "ivm_cfg.svh"

module ivm_prio #(
	parameter int N = 5
) (
	// Pending and unmasked requests
	input wire logic [N-1:0] pend,
	// Selection
	output logic valid,
	output logic [5:0] addr
);

	logic [5:0] addr_tab [N];

	// Address table, index order equals priority order
	assign addr_tab[0] = `IVM_VA_RX;
	assign addr_tab[1] = `IVM_VA_TX;
	assign addr_tab[2] = `IVM_VA_LTA;
	assign addr_tab[3] = `IVM_VA_BIDIR;
	assign addr_tab[4] = `IVM_VA_TMR;

	// Walk from lowest priority up so the highest pending wins
	always_comb
	begin
		valid = 1'b0;
		addr = 6'h00;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (pend[i])
			begin
				valid = 1'b1;
				addr = addr_tab[i];
			end
		end
	end

endmodule
`default_nettype wire

// ---- hw/ivm_top.sv ----
// Purpose: Interrupt vector generation, source masking and bidirectional pin drive
// Assumes: Single clock, synchronous active-high reset, requests synchronous to clk
// Notes: Vector and request outputs lag the request inputs by one clock
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ivm_cfg.svh"

module ivm_top (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire ivm_pkg::ivm_bus_req_t bus_req,
	output logic [7:0] rdata,
	// Interrupt sources
	input wire ivm_pkg::ivm_src_t src_req,
	// Bidirectional interrupt pin
	input wire logic bidir_pin_i,
	output logic bidir_pin_o,
	output logic bidir_pin_oe,
	// Toward the processor
	output logic cpu_irq,
	output logic [15:0] vector,
	output logic [1:0] rx_irq_sel,
	// Event interrupt
	output logic evt_irq
);
	import ivm_pkg::*;

	ivm_state_t st_ff;
	ivm_state_t nxt_st;
	logic [5:0] req_now;
	logic [4:0] pend;
	logic [5:0] rise;
	logic sel_valid;
	logic [5:0] sel_addr;
	logic rd_stat;

	// Pin is a request only while it is an input
	assign req_now = {src_req.nmi, src_req.timer, bidir_pin_i & ~st_ff.bidir_out,
		src_req.lta, src_req.tx, src_req.rx};
	assign pend = req_now[4:0] & ~st_ff.mask;
	assign rise = req_now & ~st_ff.req_prev;
	assign rd_stat = bus_req.rd && (bus_req.addr == `IVM_OFS_STAT);

	// Priority pick among pending unmasked sources
	ivm_prio #(
		.N(5)
	) u_prio (
		.pend(pend),
		.valid(sel_valid),
		.addr(sel_addr)
	);

	// Next-state logic
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.req_prev = req_now;
		// Register writes
		if (bus_req.wr)
		begin
			unique case (bus_req.addr)
				`IVM_OFS_BASE: nxt_st.base = bus_req.wdata;
				`IVM_OFS_CTRL:
				begin
					nxt_st.mask = bus_req.wdata[`IVM_CTRL_MASK_MSB:0];
					nxt_st.ris = bus_req.wdata[`IVM_CTRL_RIS_LSB+1:`IVM_CTRL_RIS_LSB];
				end
				`IVM_OFS_CFG: nxt_st.bidir_out = bus_req.wdata[`IVM_CFG_BIDIR_OUT];
				`IVM_OFS_EMSK: nxt_st.emask = bus_req.wdata[5:0];
				default: ;
			endcase
		end
		// Read data for the next cycle only; unmapped reads return zero
		nxt_st.rdata = 8'h00;
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				`IVM_OFS_BASE: nxt_st.rdata = st_ff.base;
				// Reserved bit reads zero, software must not rely on it
				`IVM_OFS_CTRL: nxt_st.rdata = {st_ff.ris, 1'b0, st_ff.mask};
				`IVM_OFS_CFG: nxt_st.rdata = {7'h00, st_ff.bidir_out};
				`IVM_OFS_STAT: nxt_st.rdata = {2'h0, st_ff.stat};
				`IVM_OFS_EMSK: nxt_st.rdata = {2'h0, st_ff.emask};
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		// Sticky events; a new edge beats the read-clear
		nxt_st.stat = (rd_stat ? 6'h00 : st_ff.stat) | rise;
		nxt_st.evt_irq = |(nxt_st.stat & nxt_st.emask);
		// Non-maskable source bypasses the mask and the ranking
		if (req_now[5])
		begin
			nxt_st.vector = {st_ff.base, 2'b00, `IVM_VA_NMI};
			nxt_st.cpu_irq = 1'b1;
		end
		else if (sel_valid)
		begin
			nxt_st.vector = {st_ff.base, 2'b00, sel_addr};
			nxt_st.cpu_irq = 1'b1;
		end
		else
		begin
			nxt_st.vector = {st_ff.base, 8'h00};
			nxt_st.cpu_irq = 1'b0;
		end
		// Output mode drives the pin from the mask bit
		nxt_st.pin_oe = st_ff.bidir_out;
		nxt_st.pin_o = st_ff.bidir_out & st_ff.mask[`IVM_MASK_BIDIR];
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_ff <= '0;
			st_ff.base <= `IVM_RST_BASE;
			st_ff.mask <= `IVM_RST_MASK;
			st_ff.ris <= `IVM_RST_RIS;
			st_ff.emask <= `IVM_RST_EMSK;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign rdata = st_ff.rdata;
	assign cpu_irq = st_ff.cpu_irq;
	assign vector = st_ff.vector;
	assign rx_irq_sel = st_ff.ris;
	assign evt_irq = st_ff.evt_irq;
	assign bidir_pin_o = st_ff.pin_o;
	assign bidir_pin_oe = st_ff.pin_oe;

	// Sequences for the checks below
	sequence seq_timer_only;
		!src_req.nmi && (pend == 5'h10);
	endsequence

	sequence seq_rx_wins;
		!src_req.nmi && pend[0] && (pend[4:1] != 4'h0);
	endsequence

	sequence seq_rx_edge;
		rise[0] && !rd_stat;
	endsequence

	sequence seq_lta_top;
		!src_req.nmi && (pend[2:0] == 3'b100);
	endsequence

	// Vector layout against the base seen one cycle earlier
	AST_VEC_FORMAT:
	assert property (@(posedge clk) disable iff (sys_rst)
		cpu_irq |-> (vector[15:8] == $past(st_ff.base)) && (vector[7:6] == 2'b00))
	else $error("vector layout wrong");

	// Non-maskable request ignores every mask bit
	AST_NMI_VEC:
	assert property (@(posedge clk) disable iff (sys_rst)
		src_req.nmi |=> cpu_irq && (vector[5:0] == `IVM_VA_NMI))
	else $error("non-maskable vector wrong");

	// Timer alone gets the lowest-priority address
	AST_TMR_VEC:
	assert property (@(posedge clk) disable iff (sys_rst)
		seq_timer_only |=> cpu_irq && (vector[5:0] == `IVM_VA_TMR))
	else $error("timer vector wrong");

	// Receiver beats any other maskable source
	AST_RX_PRIO:
	assert property (@(posedge clk) disable iff (sys_rst)
		seq_rx_wins |=> vector[5:0] == `IVM_VA_RX)
	else $error("receiver did not win");

	// Fully masked requests raise nothing toward the processor
	AST_MASK_BLOCK:
	assert property (@(posedge clk) disable iff (sys_rst)
		(!src_req.nmi && ((req_now[4:0] & ~st_ff.mask) == 5'h00)) |=> !cpu_irq)
	else $error("masked source leaked");

	// Output mode follows mask bit 3 one cycle later
	AST_PIN_DRIVE:
	assert property (@(posedge clk) disable iff (sys_rst)
		st_ff.bidir_out |=> bidir_pin_oe && (bidir_pin_o == $past(st_ff.mask[`IVM_MASK_BIDIR])))
	else $error("bidir pin drive wrong");

	// Reserved control bit never reads as one
	AST_RSV_READ:
	assert property (@(posedge clk) disable iff (sys_rst)
		(bus_req.rd && (bus_req.addr == `IVM_OFS_CTRL)) |=> !rdata[`IVM_CTRL_RSV])
	else $error("reserved bit read as one");

	// Receiver edge is caught and raised when enabled
	// A read-clear in the middle cycle may legally drop the output, so it is excluded
	AST_STICKY:
	assert property (@(posedge clk) disable iff (sys_rst)
		seq_rx_edge ##1 (nxt_st.emask[0] && !rd_stat) |-> st_ff.stat[0] ##1 evt_irq)
	else $error("event not captured");

	// Idle vector keeps a zero low byte
	AST_VEC_IDLE:
	assert property (@(posedge clk) disable iff (sys_rst)
		!cpu_irq |-> (vector[7:0] == 8'h00))
	else $error("idle vector low byte not zero");

	// Line turn-around wins once receiver and transmitter are quiet
	AST_LTA_VEC:
	assert property (@(posedge clk) disable iff (sys_rst)
		seq_lta_top |=> vector[5:0] == `IVM_VA_LTA)
	else $error("line turn-around vector wrong");

	// Any pending unmasked source raises the request line
	AST_PEND_RAISES:
	assert property (@(posedge clk) disable iff (sys_rst)
		(pend != 5'h00) |=> cpu_irq)
	else $error("pending source not raised");

	// High pin level in output mode is never a request
	AST_PIN_IGNORED:
	assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff.bidir_out && bidir_pin_i && !src_req.nmi && ((pend & 5'h17) == 5'h00)) |=> !cpu_irq)
	else $error("driven pin taken as request");

endmodule
`default_nettype wire

// ---- dv/ivm_pin_model.sv ----
// Purpose: External logic on the bidirectional interrupt pin
// Assumes: Pin has no pull; the wire level is resolved here
// Notes: Yields the wire whenever the block enables its drive
`timescale 1ns/1ps
`default_nettype none
module ivm_pin_model (
	// Block side
	input wire logic pin_o,
	input wire logic pin_oe,
	// Far side request level
	input wire logic req,
	output logic pin_i
);
	// Block drive wins while enabled, so no fight on the wire
	assign pin_i = pin_oe ? pin_o : req;
endmodule
`default_nettype wire

// ---- dv/test_interrupt_vector_and_mask.sv ----
// Purpose: Register and source tests for the vector and mask block
// Assumes: Register indices and source addresses from ivm_cfg.svh
// Notes: Reserved control bit is masked off in compares
`timescale 1ns/1ps
`default_nettype none
`include "ivm_cfg.svh"
module test_interrupt_vector_and_mask;
	import ivm_pkg::*;
	logic clk = 0;
	logic sys_rst = 1;
	ivm_bus_req_t br = '0;
	ivm_src_t sr;
	logic [5:0] s = '0;
	logic [7:0] rdata, v;
	logic pin_i, pin_o, pin_oe, cpu_irq, evt_irq;
	logic [15:0] vector;
	logic [1:0] sel;
	logic [5:0] va [0:5] = '{`IVM_VA_RX, `IVM_VA_TX, `IVM_VA_LTA, `IVM_VA_BIDIR, `IVM_VA_TMR, `IVM_VA_NMI};
	int bad_count = 0;
	int num_checks = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	// Source index 3 goes out through the pin model
	assign sr = '{nmi: s[5], timer: s[4], lta: s[2], tx: s[1], rx: s[0]};
	ivm_top uut (.clk(clk), .sys_rst(sys_rst), .bus_req(br), .rdata(rdata), .src_req(sr),
		.bidir_pin_i(pin_i), .bidir_pin_o(pin_o), .bidir_pin_oe(pin_oe), .cpu_irq(cpu_irq),
		.vector(vector), .rx_irq_sel(sel), .evt_irq(evt_irq));
	ivm_pin_model pm (.pin_o(pin_o), .pin_oe(pin_oe), .req(s[3]), .pin_i(pin_i));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		br <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		br.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		br <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		br.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Long enough for register, then registered outputs
	task automatic st;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		st;
		chk(vector, 16'h0000);
		rd(`IVM_OFS_BASE, v);
		chk(16'(v), 16'h0000);
		rd(`IVM_OFS_CTRL, v);
		chk(16'(v & 8'hDF), 16'h0000);
		wr(`IVM_OFS_BASE, 8'hA5);
		wr(`IVM_OFS_CTRL, 8'hC0);
		rd(`IVM_OFS_BASE, v);
		chk(16'(v), 16'h00A5);
		rd(`IVM_OFS_CTRL, v);
		chk(16'(v & 8'hDF), 16'h00C0);
		chk(16'(sel), 16'h0003);
		wr(`IVM_OFS_CTRL, 8'h00);
		// Each source alone, then its own mask bit; for nmi the write sets only the reserved bit, so no mask bit is set
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk) s <= 6'(1 << i);
			st;
			chk(16'(cpu_irq), 16'h0001);
			chk(vector, {8'hA5, 2'b00, va[i]});
			wr(`IVM_OFS_CTRL, 8'(1 << i));
			st;
			chk(16'(cpu_irq), 16'(i / 5));
			wr(`IVM_OFS_CTRL, 8'h00);
		end
		// All maskable pending, masked one by one in priority order
		@(posedge clk) s <= 6'h1F;
		for (int i = 0; i < 6; i++)
		begin
			wr(`IVM_OFS_CTRL, 8'((1 << i) - 1));
			st;
			chk(16'(cpu_irq), 16'(i < 5));
			chk(vector, i < 5 ? {8'hA5, 2'b00, va[i]} : 16'hA500);
		end
		@(posedge clk) s <= 6'h3F;
		st;
		chk(vector, {8'hA5, 2'b00, `IVM_VA_NMI});
		// Pin as output follows mask bit 3, request ignored
		@(posedge clk) s <= 6'h08;
		wr(`IVM_OFS_CFG, 8'h01);
		wr(`IVM_OFS_CTRL, 8'h08);
		st;
		chk(16'({pin_oe, pin_o, cpu_irq}), 16'h0006);
		wr(`IVM_OFS_CTRL, 8'h00);
		st;
		chk(16'({pin_oe, pin_o, cpu_irq}), 16'h0004);
		// Sticky status, enable mask, read clear
		wr(`IVM_OFS_CFG, 8'h00);
		@(posedge clk) s <= 6'h00;
		wr(`IVM_OFS_EMSK, 8'h01);
		rd(`IVM_OFS_STAT, v);
		st;
		chk(16'(evt_irq), 16'h0000);
		@(posedge clk) s <= 6'h01;
		st;
		chk(16'(evt_irq), 16'h0001);
		rd(`IVM_OFS_STAT, v);
		chk(16'(v), 16'h0001);
		st;
		chk(16'(evt_irq), 16'h0000);
		@(posedge clk) s <= 6'h03;
		st;
		chk(16'(evt_irq), 16'h0000);
		rd(`IVM_OFS_STAT, v);
		chk(16'(v), 16'h0002);
		// Status index is read-only, a write must not set bits
		wr(`IVM_OFS_STAT, 8'h3F);
		rd(`IVM_OFS_STAT, v);
		chk(16'(v), 16'h0000);
		// Unmapped index reads zero
		rd(3'h6, v);
		chk(16'(v), 16'h0000);
		close_out;
	end
	// Watchdog: the run needs well under 1000 cycles
	initial
	begin
		#20000;
		bad_count++;
		close_out;
	end
endmodule
`default_nettype wire
